/* rtl/sled_top.sv */
// sled_top.sv: status led pattern driver for general, fieldbus and ethernet leds
// assumes state inputs come from asynchronous logic or pins; leds are active high
`timescale 1ns/100ps
`default_nettype none
`include "sled_cfg.svh"
module sled_top #(
   parameter logic [`SLED_PRE_W-1:0] FLICKER_CYC = `SLED_PRE_W'(`SLED_FLICKER_CYC),
   parameter logic [`SLED_PRE_W-1:0] BLINK_CYC = `SLED_PRE_W'(`SLED_BLINK_CYC),
   parameter logic [`SLED_PRE_W-1:0] GAP_CYC = `SLED_PRE_W'(`SLED_GAP_CYC)
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic initBusy,
   input wire logic initFault,
   input wire logic ctrlEnabled,
   input wire logic fwDownload,
   input wire logic startupDone,
   input wire sled_pkg::sled_can_t canState,
   input wire logic canDownload,
   input wire logic canDetect,
   input wire logic canWarning,
   input wire logic canGuardEvent,
   input wire logic canSyncTimeout,
   input wire logic canBusOff,
   input wire sled_pkg::sled_eth_t ethState,
   input wire logic ethError,
   output logic statusGreen,
   output logic statusRed,
   output logic canGreen,
   output logic canRed,
   output logic ethGreen,
   output logic ethRed
);
   import sled_pkg::*;
   localparam int NIN = 16;
   logic [NIN-1:0] rawIn;
   logic [NIN-1:0] sync1_r;
   logic [NIN-1:0] sync2_r;
   logic sInitBusy, sInitFault, sEnabled, sFwDl, sStartup;
   logic sCanDl, sCanDet, sCanWarn, sCanGuard, sCanSync, sCanOff, sEthErr;
   sled_can_t sCan;
   sled_eth_t sEth;
   logic ethErrSeen_r;
   sled_pat_t patStG, patStR, patCanG, patCanR, patEthG, patEthR;
   logic [5:0] lamp;
   logic [5:0] led_r;
   sled_tick_if tick ();

   assign rawIn = {initBusy, initFault, ctrlEnabled, fwDownload, startupDone,
                   canDownload, canDetect, canWarning, canGuardEvent, canSyncTimeout,
                   canBusOff, ethError, 1'b0, canState[1:0], 1'b0};
   // two-stage synchroniser on every state input
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= rawIn;
         sync2_r <= sync1_r;
      end
   end
   logic [2:0] ethS1_r, ethS2_r;
   logic canHi1_r, canHi2_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ethS1_r <= 3'h0;
         ethS2_r <= 3'h0;
         canHi1_r <= 1'b0;
         canHi2_r <= 1'b0;
      end else begin
         ethS1_r <= ethState;
         ethS2_r <= ethS1_r;
         canHi1_r <= canState[2];
         canHi2_r <= canHi1_r;
      end
   end
   assign {sInitBusy, sInitFault, sEnabled, sFwDl, sStartup} = sync2_r[15:11];
   assign {sCanDl, sCanDet, sCanWarn, sCanGuard, sCanSync, sCanOff, sEthErr} = sync2_r[10:4];
   assign sCan = sled_can_t'({canHi2_r, sync2_r[2:1]});
   assign sEth = sled_eth_t'(ethS2_r);

   // ethernet error seen after startup stays latched until reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ethErrSeen_r <= 1'b0;
      end else if (sEthErr && sStartup) begin
         ethErrSeen_r <= 1'b1;
      end
   end

   // general status led, fault first
   always_comb begin
      patStG = SLED_PAT_OFF;
      patStR = SLED_PAT_OFF;
      if (sInitFault) begin
         patStR = SLED_PAT_BLINK;
      end else if (sFwDl) begin
         patStG = SLED_PAT_FLICKER;
      end else if (sInitBusy || !sEnabled) begin
         patStR = SLED_PAT_ON;
      end else begin
         patStG = SLED_PAT_ON;
      end
   end

   // fieldbus run led
   always_comb begin
      patCanG = SLED_PAT_OFF;
      if (!sStartup) begin
         patCanG = SLED_PAT_OFF;
      end else if (sCanDet) begin
         patCanG = SLED_PAT_FLICKER;
      end else if (sCanDl) begin
         patCanG = SLED_PAT_FLASH3;
      end else begin
         case (sCan)
            SLED_CAN_STOPPED: patCanG = SLED_PAT_FLASH1;
            SLED_CAN_PREOP: patCanG = SLED_PAT_BLINK;
            SLED_CAN_OPER: patCanG = SLED_PAT_ON;
            default: patCanG = SLED_PAT_OFF;
         endcase
      end
   end

   // fieldbus error led, bus off outranks all flashes
   always_comb begin
      if (!sStartup) begin
         patCanR = SLED_PAT_OFF;
      end else if (sCanOff) begin
         patCanR = SLED_PAT_ON;
      end else if (sCanSync) begin
         patCanR = SLED_PAT_FLASH3;
      end else if (sCanGuard) begin
         patCanR = SLED_PAT_FLASH2;
      end else if (sCanWarn) begin
         patCanR = SLED_PAT_FLASH1;
      end else if (sCanDet) begin
         patCanR = SLED_PAT_FLICKER;
      end else begin
         patCanR = SLED_PAT_OFF;
      end
   end

   // ethernet leds
   always_comb begin
      patEthR = (sStartup && (ethErrSeen_r || sEthErr)) ? SLED_PAT_ON : SLED_PAT_OFF;
      if (!sStartup) begin
         patEthG = SLED_PAT_OFF;
      end else begin
         case (sEth)
            SLED_ETH_PREOP1: patEthG = SLED_PAT_FLASH1;
            SLED_ETH_PREOP2: patEthG = SLED_PAT_FLASH2;
            SLED_ETH_READY: patEthG = SLED_PAT_FLASH3;
            SLED_ETH_STOPPED: patEthG = SLED_PAT_BLINK;
            SLED_ETH_BASIC: patEthG = SLED_PAT_FLICKER;
            SLED_ETH_OPER: patEthG = SLED_PAT_ON;
            default: patEthG = SLED_PAT_OFF;
         endcase
      end
   end

   sled_timebase uTimebase (
      .clock(clock),
      .resetn(resetn),
      .flickerCyc(FLICKER_CYC),
      .blinkCyc(BLINK_CYC),
      .gapCyc(GAP_CYC),
      .tick(tick.src)
   );

   sled_pat_t pats [6];
   logic [5:0] invs;
   assign pats[0] = patStG;
   assign pats[1] = patStR;
   assign pats[2] = patCanG;
   assign pats[3] = patCanR;
   assign pats[4] = patEthG;
   assign pats[5] = patEthR;
   // red fieldbus flicker runs in antiphase to green
   assign invs = 6'b00_1000;

   for (genvar i = 0; i < 6; i++) begin : gLed
      sled_pattern uPat (
         .pat(pats[i]),
         .invFlicker(invs[i]),
         .tick(tick.dst),
         .lamp(lamp[i])
      );
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         led_r <= 6'h00;
      end else begin
         led_r <= lamp;
      end
   end
   assign {ethRed, ethGreen, canRed, canGreen, statusRed, statusGreen} = led_r;
endmodule // sled_top
`default_nettype wire

/* rtl/sled_cfg.svh */
// sled_cfg.svh: timing constants for the status led driver
// assumes a 100 MHz system clock
`ifndef SLED_CFG_SVH
`define SLED_CFG_SVH
`define SLED_CLK_MHZ 100
// flicker half period 50 ms, blink/flash half period 200 ms, burst gap 1000 ms
`define SLED_FLICKER_MS 50
`define SLED_BLINK_MS 200
`define SLED_GAP_MS 1000
`define SLED_FLICKER_CYC (`SLED_FLICKER_MS * 1000 * `SLED_CLK_MHZ)
`define SLED_BLINK_CYC (`SLED_BLINK_MS * 1000 * `SLED_CLK_MHZ)
`define SLED_GAP_CYC (`SLED_GAP_MS * 1000 * `SLED_CLK_MHZ)
`define SLED_PRE_W 28
`endif

/* rtl/sled_pkg.sv */
// sled_pkg.sv: types of the status led driver
// assumes sled_cfg.svh is on the include path
package sled_pkg;
   typedef enum logic [2:0] {
      SLED_PAT_OFF = 3'h0,
      SLED_PAT_ON = 3'h1,
      SLED_PAT_FLICKER = 3'h2,
      SLED_PAT_BLINK = 3'h3,
      SLED_PAT_FLASH1 = 3'h4,
      SLED_PAT_FLASH2 = 3'h5,
      SLED_PAT_FLASH3 = 3'h6
   } sled_pat_t;
   typedef enum logic [2:0] {
      SLED_CAN_INIT = 3'h0,
      SLED_CAN_STOPPED = 3'h1,
      SLED_CAN_PREOP = 3'h2,
      SLED_CAN_OPER = 3'h3
   } sled_can_t;
   typedef enum logic [2:0] {
      SLED_ETH_NOTACT = 3'h0,
      SLED_ETH_PREOP1 = 3'h1,
      SLED_ETH_PREOP2 = 3'h2,
      SLED_ETH_READY = 3'h3,
      SLED_ETH_STOPPED = 3'h4,
      SLED_ETH_BASIC = 3'h5,
      SLED_ETH_OPER = 3'h6
   } sled_eth_t;
endpackage

/* rtl/sled_tick_if.sv */
// sled_tick_if.sv: timing phases shared by the pattern generators
// assumes one producer (sled_timebase) and many consumers
`timescale 1ns/100ps
`default_nettype none
interface sled_tick_if;
   logic flicker;
   logic blink;
   logic [3:0] slot;
   modport src (output flicker, output blink, output slot);
   modport dst (input flicker, input blink, input slot);
endinterface
`default_nettype wire

/* rtl/sled_timebase.sv */
// sled_timebase.sv: prescalers making flicker, blink and burst slot phases
// assumes prescaler periods held stable by the top
`timescale 1ns/100ps
`default_nettype none
`include "sled_cfg.svh"
module sled_timebase (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [`SLED_PRE_W-1:0] flickerCyc,
   input wire logic [`SLED_PRE_W-1:0] blinkCyc,
   input wire logic [`SLED_PRE_W-1:0] gapCyc,
   sled_tick_if.src tick
);
   logic [`SLED_PRE_W-1:0] flkCnt_r;
   logic [`SLED_PRE_W-1:0] blkCnt_r;
   logic [`SLED_PRE_W-1:0] blinkCnt_r;
   logic flk_r;
   logic blk_r;
   logic [3:0] slot_r;
   logic blkWrap;
   // slots 0..5 are three on/off flash pairs, slot 6 is the long gap
   logic [`SLED_PRE_W-1:0] blkLimit;
   assign blkLimit = (slot_r == 4'h6) ? gapCyc : blinkCyc;
   assign blkWrap = (blkCnt_r >= blkLimit - 1'b1);
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flkCnt_r <= '0;
         flk_r <= 1'b0;
      end else if (flkCnt_r >= flickerCyc - 1'b1) begin
         flkCnt_r <= '0;
         flk_r <= ~flk_r;
      end else begin
         flkCnt_r <= flkCnt_r + 1'b1;
      end
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         blkCnt_r <= '0;
         slot_r <= 4'h0;
      end else if (blkWrap) begin
         blkCnt_r <= '0;
         slot_r <= (slot_r == 4'h6) ? 4'h0 : slot_r + 4'h1;
      end else begin
         blkCnt_r <= blkCnt_r + 1'b1;
      end
   end
   // blink runs apart from the burst slots so on and off halves stay equal
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         blinkCnt_r <= '0;
         blk_r <= 1'b0;
      end else if (blinkCnt_r >= blinkCyc - 1'b1) begin
         blinkCnt_r <= '0;
         blk_r <= ~blk_r;
      end else begin
         blinkCnt_r <= blinkCnt_r + 1'b1;
      end
   end
   assign tick.flicker = flk_r;
   assign tick.blink = blk_r;
   assign tick.slot = slot_r;
endmodule // sled_timebase
`default_nettype wire

/* rtl/sled_pattern.sv */
// sled_pattern.sv: turns a pattern code into a lamp level
// assumes phases from sled_timebase
`timescale 1ns/100ps
`default_nettype none
module sled_pattern (
   input wire sled_pkg::sled_pat_t pat,
   input wire logic invFlicker,
   sled_tick_if.dst tick,
   output logic lamp
);
   import sled_pkg::*;
   logic flashOn;
   logic [3:0] lim;
   always_comb begin
      case (pat)
         SLED_PAT_FLASH1: lim = 4'h1;
         SLED_PAT_FLASH2: lim = 4'h2;
         default: lim = 4'h3;
      endcase
   end
   // even slots are lit, up to n flashes, then dark to the gap
   assign flashOn = !tick.slot[0] && (tick.slot < {lim[2:0], 1'b0});
   always_comb begin
      case (pat)
         SLED_PAT_OFF: lamp = 1'b0;
         SLED_PAT_ON: lamp = 1'b1;
         SLED_PAT_FLICKER: lamp = tick.flicker ^ invFlicker;
         SLED_PAT_BLINK: lamp = tick.blink;
         default: lamp = flashOn;
      endcase
   end
endmodule // sled_pattern
`default_nettype wire

/* verif/sled_led_watch.sv */
// sled_led_watch.sv: operator model counting flashes and lit time on one lamp
// assumes the lamp is sampled on the system clock; clear high zeroes the counts
`timescale 1ns/100ps
`default_nettype none
module sled_led_watch (
   input wire logic clock,
   input wire logic clear,
   input wire logic lamp,
   output logic [7:0] edges,
   output logic [7:0] lit
);
   logic prev_r;
   always_ff @(posedge clock) begin
      prev_r <= lamp;
      edges <= clear ? 8'h00 : edges + 8'(lamp & ~prev_r);
      lit <= clear ? 8'h00 : lit + 8'(lamp);
   end
endmodule // sled_led_watch
`default_nettype wire

/* verif/sled_top_properties.sv */
// sled_top_properties.sv: assertions on the status led driver ports
// assumes leds follow inputs held for four edges
`timescale 1ns/100ps
`default_nettype none
module sled_top_properties (
   input wire logic clock,
   input wire logic resetn,
   input wire logic initBusy,
   input wire logic initFault,
   input wire logic fwDownload,
   input wire logic startupDone,
   input wire sled_pkg::sled_can_t canState,
   input wire logic canDownload,
   input wire logic canDetect,
   input wire logic canWarning,
   input wire logic canGuardEvent,
   input wire logic canSyncTimeout,
   input wire logic canBusOff,
   input wire sled_pkg::sled_eth_t ethState,
   input wire logic ethError,
   input wire logic statusGreen,
   input wire logic statusRed,
   input wire logic canGreen,
   input wire logic canRed,
   input wire logic ethGreen,
   input wire logic ethRed
);
   import sled_pkg::*;
   logic canErr;
   assign canErr = canWarning | canGuardEvent | canSyncTimeout | canBusOff;
   // low for the first edge after reset, while the input synchronisers refill
   logic live_r;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         live_r <= 1'b0;
      end else begin
         live_r <= 1'b1;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn || !live_r);
   sequence s_held(c);
      c [*4];
   endsequence
   property p_busDark;
      s_held(!startupDone) |-> !(canGreen | canRed | ethGreen | ethRed);
   endproperty
   a_busDark: assert property (p_busDark) else $error("bus led lit early");
   property p_initRed;
      s_held(initBusy && !initFault && !fwDownload) |-> statusRed && !statusGreen;
   endproperty
   a_initRed: assert property (p_initRed) else $error("no red in init");
   property p_faultDark;
      s_held(initFault) |-> !statusGreen;
   endproperty
   a_faultDark: assert property (p_faultDark) else $error("green on fault");
   property p_fwGreen;
      s_held(fwDownload && !initFault) |-> !statusRed;
   endproperty
   a_fwGreen: assert property (p_fwGreen) else $error("red in download");
   property p_busOff;
      s_held(startupDone && canBusOff) |-> canRed;
   endproperty
   a_busOff: assert property (p_busOff) else $error("bus off not lit");
   property p_redOff;
      s_held(startupDone && !canErr && !canDetect) |-> !canRed;
   endproperty
   a_redOff: assert property (p_redOff) else $error("red lit no error");
   property p_alt;
      s_held(startupDone && canDetect && !canErr) |-> canGreen != canRed;
   endproperty
   a_alt: assert property (p_alt) else $error("detect not alternate");
   property p_canOn;
      s_held(startupDone && canState == SLED_CAN_OPER && !canDetect && !canDownload)
         |-> canGreen;
   endproperty
   a_canOn: assert property (p_canOn) else $error("oper not steady");
   property p_ethOff;
      s_held(startupDone && ethState == SLED_ETH_NOTACT) |-> !ethGreen;
   endproperty
   a_ethOff: assert property (p_ethOff) else $error("notact lit");
   property p_ethErr;
      s_held(startupDone && ethError) |-> ethRed;
   endproperty
   a_ethErr: assert property (p_ethErr) else $error("eth error dark");
endmodule // sled_top_properties
bind sled_top sled_top_properties u_props (
   .clock(clock), .resetn(resetn), .initBusy(initBusy), .initFault(initFault),
   .fwDownload(fwDownload), .startupDone(startupDone), .canState(canState),
   .canDownload(canDownload), .canDetect(canDetect), .canWarning(canWarning),
   .canGuardEvent(canGuardEvent), .canSyncTimeout(canSyncTimeout), .canBusOff(canBusOff),
   .ethState(ethState), .ethError(ethError), .statusGreen(statusGreen),
   .statusRed(statusRed), .canGreen(canGreen), .canRed(canRed), .ethGreen(ethGreen),
   .ethRed(ethRed)
);
`default_nettype wire

/* verif/sled_top_tb.sv */
// sled_top_tb.sv: self-checking bench for the status led driver
// assumes short prescalers 2/4/10 so a flash burst repeats every 34 cycles
`timescale 1ns/100ps
`default_nettype none
module sled_top_tb;
   import sled_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic initBusy, initFault, ctrlEnabled, fwDownload, startupDone, canDownload;
   logic canDetect, canWarning, canGuardEvent, canSyncTimeout, canBusOff, ethError;
   sled_can_t canState;
   sled_eth_t ethState;
   wire logic [5:0] leds;
   logic clear = 1'b1;
   logic [2:0] sel = 3'h0;
   logic [7:0] edges, lit;
   int nFail = 0;
   int checks = 0;
   always #5 clock = ~clock;
   sled_top #(.FLICKER_CYC(28'h000_0002), .BLINK_CYC(28'h000_0004),
      .GAP_CYC(28'h000_000a)) dut (
      .clock(clock), .resetn(resetn), .initBusy(initBusy), .initFault(initFault),
      .ctrlEnabled(ctrlEnabled), .fwDownload(fwDownload), .startupDone(startupDone),
      .canState(canState), .canDownload(canDownload), .canDetect(canDetect),
      .canWarning(canWarning), .canGuardEvent(canGuardEvent),
      .canSyncTimeout(canSyncTimeout), .canBusOff(canBusOff), .ethState(ethState),
      .ethError(ethError), .statusGreen(leds[0]), .statusRed(leds[1]),
      .canGreen(leds[2]), .canRed(leds[3]), .ethGreen(leds[4]), .ethRed(leds[5]));
   sled_led_watch watch (.clock(clock), .clear(clear), .lamp(leds[sel]), .edges(edges),
      .lit(lit));
   task automatic chk(input logic [2:0] s, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         nFail++;
         $display("[FAIL] lamp%0d expected %0d seen %0d", s, exp, seen);
      end
   endtask
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", checks, nFail);
      if (nFail == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // settle, then count over two whole burst periods
   task automatic pat(input logic [2:0] s, input sled_pat_t k);
      sel <= s;
      clear <= 1'b1;
      repeat (40) @(posedge clock);
      clear <= 1'b0;
      repeat (68) @(posedge clock);
      @(negedge clock);
      case (k)
         SLED_PAT_OFF: chk(s, lit, 8'h00);
         SLED_PAT_ON: chk(s, lit, 8'h44);
         SLED_PAT_FLICKER: begin
            chk(s, edges, 8'h11);
            chk(s, lit, 8'h22);
         end
         SLED_PAT_BLINK: begin
            chk(s, 8'(edges inside {[8:9]}), 8'h01);
            chk(s, 8'(lit inside {[32:36]}), 8'h01);
         end
         default: begin
            chk(s, edges, 8'(2 * (int'(k) - 3)));
            chk(s, lit, 8'(8 * (int'(k) - 3)));
         end
      endcase
      @(posedge clock);
   endtask
   task automatic idle();
      initBusy <= 1'b0;
      initFault <= 1'b0;
      ctrlEnabled <= 1'b1;
      fwDownload <= 1'b0;
      startupDone <= 1'b1;
      canState <= SLED_CAN_OPER;
      canDownload <= 1'b0;
      canDetect <= 1'b0;
      canWarning <= 1'b0;
      canGuardEvent <= 1'b0;
      canSyncTimeout <= 1'b0;
      canBusOff <= 1'b0;
      ethState <= SLED_ETH_OPER;
      ethError <= 1'b0;
      @(posedge clock);
   endtask
   task automatic scStatus();
      initBusy <= 1'b1;
      pat(1, SLED_PAT_ON);
      pat(0, SLED_PAT_OFF);
      initBusy <= 1'b0;
      ctrlEnabled <= 1'b0;
      pat(1, SLED_PAT_ON);
      ctrlEnabled <= 1'b1;
      pat(0, SLED_PAT_ON);
      pat(1, SLED_PAT_OFF);
      fwDownload <= 1'b1;
      pat(0, SLED_PAT_FLICKER);
      initFault <= 1'b1;
      pat(1, SLED_PAT_BLINK);
      pat(0, SLED_PAT_OFF);
   endtask
   task automatic scGate();
      startupDone <= 1'b0;
      canBusOff <= 1'b1;
      ethError <= 1'b1;
      pat(2, SLED_PAT_OFF);
      pat(3, SLED_PAT_OFF);
      pat(4, SLED_PAT_OFF);
      pat(5, SLED_PAT_OFF);
   endtask
   task automatic scCanGreen();
      canState <= SLED_CAN_INIT;
      pat(2, SLED_PAT_OFF);
      canState <= SLED_CAN_STOPPED;
      pat(2, SLED_PAT_FLASH1);
      canState <= SLED_CAN_PREOP;
      pat(2, SLED_PAT_BLINK);
      canState <= SLED_CAN_OPER;
      pat(2, SLED_PAT_ON);
      canDownload <= 1'b1;
      pat(2, SLED_PAT_FLASH3);
      canDetect <= 1'b1;
      pat(2, SLED_PAT_FLICKER);
      pat(3, SLED_PAT_FLICKER);
   endtask
   task automatic scCanRed();
      pat(3, SLED_PAT_OFF);
      canWarning <= 1'b1;
      pat(3, SLED_PAT_FLASH1);
      canGuardEvent <= 1'b1;
      pat(3, SLED_PAT_FLASH2);
      canSyncTimeout <= 1'b1;
      pat(3, SLED_PAT_FLASH3);
      canBusOff <= 1'b1;
      pat(3, SLED_PAT_ON);
   endtask
   task automatic scEth();
      ethState <= SLED_ETH_NOTACT;
      pat(4, SLED_PAT_OFF);
      ethState <= SLED_ETH_PREOP1;
      pat(4, SLED_PAT_FLASH1);
      ethState <= SLED_ETH_PREOP2;
      pat(4, SLED_PAT_FLASH2);
      ethState <= SLED_ETH_READY;
      pat(4, SLED_PAT_FLASH3);
      ethState <= SLED_ETH_STOPPED;
      pat(4, SLED_PAT_BLINK);
      ethState <= SLED_ETH_BASIC;
      pat(4, SLED_PAT_FLICKER);
      ethState <= SLED_ETH_OPER;
      pat(4, SLED_PAT_ON);
      pat(5, SLED_PAT_OFF);
      ethError <= 1'b1;
      pat(5, SLED_PAT_ON);
      ethError <= 1'b0;
      pat(5, SLED_PAT_ON);
   endtask
   // mid-run reset darkens both ethernet lamps and drops the latched ethernet error
   task automatic scReset();
      resetn <= 1'b0;
      pat(4, SLED_PAT_OFF);
      pat(5, SLED_PAT_OFF);
      resetn <= 1'b1;
      pat(5, SLED_PAT_OFF);
      pat(4, SLED_PAT_ON);
   endtask
   initial begin
      repeat (10000) @(posedge clock);
      nFail++;
      giveVerdict();
   end
   initial begin
      idle();
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      scStatus();
      idle();
      scGate();
      idle();
      scCanGreen();
      idle();
      scCanRed();
      idle();
      scEth();
      scReset();
      giveVerdict();
   end
endmodule // sled_top_tb
`default_nettype wire
